/* File: include/servo_pkg.sv */
/*
 * constants, field layouts and state codes of the servo input function decoder.
 * assumes a 32-bit axi4-lite register bus and a single 125 mhz system clock.
 */
`default_nettype none
package servo_pkg;
	// bus and data widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned SIGN_BIT = DATA_W - 1;

	// discrete inputs and target records
	localparam int unsigned NUM_INPUTS = 8;
	localparam int unsigned NUM_RECORDS = 8;
	localparam int unsigned IDX_W = 3;
	localparam int unsigned IN_ENABLE = 0;
	localparam int unsigned IN_UPPER = 1;
	localparam int unsigned IN_LOWER = 2;
	localparam int unsigned IN_START = 3;
	localparam int unsigned IN_SPARE = 4;
	localparam int unsigned IN_SEL0 = 5;
	localparam int unsigned IN_SEL1 = 6;
	localparam int unsigned IN_SEL2 = 7;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RANGE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SETPOS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h20;
	localparam logic [ADDR_W-1:0] TARGET_MASK = 8'he3;
	localparam int unsigned TGT_IDX_LO = 2;
	localparam int unsigned TGT_IDX_HI = 4;

	// control register fields
	localparam int unsigned CTRL_W = 8;
	localparam int unsigned CTRL_FIELDBUS = 0;
	localparam int unsigned CTRL_MODE_LO = 1;
	localparam int unsigned CTRL_MODE_HI = 2;
	localparam int unsigned CTRL_MONITOR = 3;
	localparam int unsigned CTRL_NC = 4;
	localparam int unsigned CTRL_IMMEDIATE = 5;
	localparam int unsigned CTRL_TURNTABLE = 6;
	localparam int unsigned CTRL_RELATIVE = 7;

	// command register fields
	localparam int unsigned CMD_START = 0;
	localparam int unsigned CMD_IDX_LO = 1;
	localparam int unsigned CMD_IDX_HI = CMD_IDX_LO + IDX_W - 1;
	localparam int unsigned CMD_CLR_ERR = 4;

	// status register fields
	localparam int unsigned ST_IN_LO = 0;
	localparam int unsigned ST_IN_HI = NUM_INPUTS - 1;
	localparam int unsigned ST_ENABLE = 8;
	localparam int unsigned ST_BUSY = 9;
	localparam int unsigned ST_PENDING = 10;
	localparam int unsigned ST_POS_ERR = 11;
	localparam int unsigned ST_IDX_LO = 12;
	localparam int unsigned ST_IDX_HI = ST_IDX_LO + IDX_W - 1;

	// reset values; range counts 1/10000 revolution
	localparam logic [DATA_W-1:0] RANGE_RESET = 32'h0000_2710;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_CURRENT = 2'h0,
		MODE_SPEED = 2'h1,
		MODE_POSITION = 2'h2
	} op_mode_t;

	typedef enum logic [1:0] {
		JOB_IDLE = 2'h1,
		JOB_RUN = 2'h2
	} job_state_t;
endpackage : servo_pkg
`default_nettype wire

/* File: hw/input_sync.sv */
/*
 * two-stage synchroniser and rising edge detector for the discrete inputs.
 * assumes raw pins may change at any time relative to clk_sys_in.
 */
`timescale 1ns/1ns
`default_nettype none
module input_sync (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// raw pins
	input wire logic [servo_pkg::NUM_INPUTS-1:0] raw_in,
	// synchronised levels and edges
	output logic [servo_pkg::NUM_INPUTS-1:0] level_out,
	output logic [servo_pkg::NUM_INPUTS-1:0] rise_out
);
	typedef struct packed {
		logic [servo_pkg::NUM_INPUTS-1:0] meta;
		logic [servo_pkg::NUM_INPUTS-1:0] stable;
		logic [servo_pkg::NUM_INPUTS-1:0] prev;
	} sync_t;

	sync_t q;
	sync_t next_q;

	// ****************************************
	// synchroniser chain
	// ****************************************
	always_comb begin
		next_q.meta = raw_in; // see R25
		next_q.stable = q.meta;
		next_q.prev = q.stable;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	for (genvar i = 0; i < servo_pkg::NUM_INPUTS; i++) begin : g_edge
		assign rise_out[i] = q.stable[i] & ~q.prev[i]; // see R25
	end
	assign level_out = q.stable;

	a_rise_once: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // see R25
		rise_out[servo_pkg::IN_START] |=> !rise_out[servo_pkg::IN_START])
		else $error("edge pulse lasted more than one cycle");
endmodule : input_sync
`default_nettype wire

/* File: hw/servo_input_decoder.sv */
/*
 * servo input function decoder: discrete input decode, limit handling,
 * positioning job start with one pending slot, axi4-lite register slave.
 * assumes limit switches and a plc drive the pins, controller logic downstream.
 */
// What this block does
// R1: absolute turntable targets accepted only from zero to the positioning range.
// R2: absolute turntable job whose target equals setpoint position starts no motion.
// R3: relative turntable targets span minus to plus range; full range still moves.
// R4: range limit counts in ten-thousandths of a revolution.
// R5: deferred requests overwrite one pending slot; last runs after current job.
// R6: eight discrete inputs whose functions follow the operating mode.
// R7: fieldbus mode keeps only enable and the two limit inputs.
// R8: shared pins drive as outputs whenever no input function uses them.
// R9: normally closed means low is actuated; normally open means high.
// R10: a missing signal counts as actuated with normally closed contacts.
// R11: unmonitored current/speed: upper gives setpoint zero or hold, lower inverts.
// R12: monitored upper limit blocks positive setpoints and forces proportional control.
// R13: monitored lower limit blocks negative setpoints and forces proportional control.
// R14: positioning without monitoring: limits raise no positioning error.
// R15: positioning with monitoring: an actuated limit raises positioning error.
// R16: limit function applies to both limit inputs together.
// R17: i/o mode enables only after a rising enable edge; fieldbus needs level.
// R18: setpoint zero overrides the external setpoint, ramps stay active.
// R19: hold stops the motor and holds position in positioning mode; the code drives hold_out only outside positioning mode.
// R20: inversion negates the current or speed setpoint sign.
// R21: select bit zero picks one of two fixed setpoints in current/speed.
// R22: rising start edge launches next job now or after the running one.
// R23: three select bits form the target record index, captured at start.
// R24: immediate bit zero defers the start, one aborts and starts.
// R25: inputs synchronised before decode; each rising edge gives one pulse.
`timescale 1ns/1ns
`default_nettype none
module servo_input_decoder #(
	parameter logic HALT_PRESET = 1'h0
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// axi4-lite write
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [servo_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [servo_pkg::DATA_W-1:0] s_axi_wdata_in,
	input wire logic [servo_pkg::STRB_W-1:0] s_axi_wstrb_in,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// axi4-lite read
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [servo_pkg::ADDR_W-1:0] s_axi_araddr_in,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [servo_pkg::DATA_W-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// discrete input pins
	input wire logic enable_input_in,
	input wire logic upper_limit_input_in,
	input wire logic lower_limit_input_in,
	input wire logic select_bit0_input_in,
	input wire logic select_bit1_input_in,
	input wire logic select_bit2_input_in,
	// shared pins
	input wire logic start_input_in,
	output logic start_input_out,
	output logic start_input_oe_out,
	input wire logic spare_io_b_in,
	output logic spare_io_b_out,
	output logic spare_io_b_oe_out,
	input wire logic output_one_in,
	input wire logic output_two_in,
	// controller side
	output logic drive_enable_out,
	output logic setpoint_zero_out,
	output logic hold_out,
	output logic invert_out,
	output logic fixed_select_out,
	output logic block_pos_out,
	output logic block_neg_out,
	output logic p_only_out,
	output logic pos_error_out,
	// positioning side
	input wire logic job_done_in,
	output logic job_start_out,
	output logic job_abort_out,
	output logic job_relative_out,
	output logic [servo_pkg::DATA_W-1:0] job_target_out,
	output logic [servo_pkg::IDX_W-1:0] job_index_out
);
	typedef struct packed {
		logic aw_got;
		logic [servo_pkg::ADDR_W-1:0] awaddr;
		logic w_got;
		logic [servo_pkg::DATA_W-1:0] wdata;
		logic [servo_pkg::STRB_W-1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [servo_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic [servo_pkg::CTRL_W-1:0] ctrl;
		logic [servo_pkg::DATA_W-1:0] range;
		logic [servo_pkg::NUM_RECORDS-1:0][servo_pkg::DATA_W-1:0] target;
		logic [servo_pkg::DATA_W-1:0] setpos;
		logic en_armed;
		servo_pkg::job_state_t job;
		logic pending;
		logic [servo_pkg::IDX_W-1:0] pend_idx;
		logic pos_err;
		logic drive_en;
		logic sp_zero;
		logic hold;
		logic invert;
		logic fixed_sel;
		logic blk_pos;
		logic blk_neg;
		logic p_only;
		logic start_p;
		logic abort_p;
		logic rel_p;
		logic [servo_pkg::DATA_W-1:0] tgt;
		logic [servo_pkg::IDX_W-1:0] idx;
	} state_t;

	state_t q;
	state_t next_q;

	logic [servo_pkg::NUM_INPUTS-1:0] lvl;
	logic [servo_pkg::NUM_INPUTS-1:0] rise;
	logic io, pos, mon, nc, tt, rel, imm;
	logic up_act, lo_act, wr_fire, done, busy_eff;
	logic [servo_pkg::DATA_W-1:0] ctrl_m;
	logic cmd_start, clr_err, req, launch, t_ok, motion;
	logic [servo_pkg::IDX_W-1:0] cmd_idx, req_idx, l_idx;
	logic [servo_pkg::DATA_W-1:0] t_sel;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic actuated(input logic nc_type, input logic level);
		return nc_type ? ~level : level;
	endfunction : actuated

	function automatic logic reg_hit(input logic [servo_pkg::ADDR_W-1:0] a);
		return a == servo_pkg::OFS_CTRL || a == servo_pkg::OFS_RANGE || a == servo_pkg::OFS_SETPOS
			|| a == servo_pkg::OFS_CMD || a == servo_pkg::OFS_STATUS
			|| (a & servo_pkg::TARGET_MASK) == servo_pkg::OFS_TARGET;
	endfunction : reg_hit

	function automatic logic [servo_pkg::DATA_W-1:0] merge(input logic [servo_pkg::DATA_W-1:0] old,
		input logic [servo_pkg::DATA_W-1:0] wd, input logic [servo_pkg::STRB_W-1:0] st);
		logic [servo_pkg::DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < servo_pkg::STRB_W; b++) begin
			if (st[b]) begin
				r[b*servo_pkg::BYTE_W +: servo_pkg::BYTE_W] = wd[b*servo_pkg::BYTE_W +: servo_pkg::BYTE_W];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [servo_pkg::DATA_W-1:0] read_word(input state_t s,
		input logic [servo_pkg::ADDR_W-1:0] a, input logic [servo_pkg::NUM_INPUTS-1:0] lv);
		logic [servo_pkg::DATA_W-1:0] w;
		w = '0;
		if (a == servo_pkg::OFS_CTRL) begin
			w = servo_pkg::DATA_W'(s.ctrl);
		end else if (a == servo_pkg::OFS_RANGE) begin
			w = s.range;
		end else if (a == servo_pkg::OFS_SETPOS) begin
			w = s.setpos;
		end else if (a == servo_pkg::OFS_STATUS) begin
			w[servo_pkg::ST_IN_HI:servo_pkg::ST_IN_LO] = lv;
			w[servo_pkg::ST_ENABLE] = s.drive_en;
			w[servo_pkg::ST_BUSY] = s.job == servo_pkg::JOB_RUN;
			w[servo_pkg::ST_PENDING] = s.pending;
			w[servo_pkg::ST_POS_ERR] = s.pos_err;
			w[servo_pkg::ST_IDX_HI:servo_pkg::ST_IDX_LO] = s.idx;
		end else if ((a & servo_pkg::TARGET_MASK) == servo_pkg::OFS_TARGET) begin
			w = s.target[a[servo_pkg::TGT_IDX_HI:servo_pkg::TGT_IDX_LO]];
		end
		return w;
	endfunction : read_word

	// ****************************************
	// input synchronisation
	// ****************************************
	input_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.raw_in({select_bit2_input_in, select_bit1_input_in, select_bit0_input_in, spare_io_b_in,
			start_input_in, lower_limit_input_in, upper_limit_input_in, enable_input_in}), // see R6
		.level_out(lvl),
		.rise_out(rise)
	);

	assign io = !q.ctrl[servo_pkg::CTRL_FIELDBUS];
	assign pos = q.ctrl[servo_pkg::CTRL_MODE_HI:servo_pkg::CTRL_MODE_LO] == servo_pkg::MODE_POSITION;
	assign mon = q.ctrl[servo_pkg::CTRL_MONITOR]; // see R16
	assign nc = q.ctrl[servo_pkg::CTRL_NC];
	assign tt = q.ctrl[servo_pkg::CTRL_TURNTABLE];
	assign rel = q.ctrl[servo_pkg::CTRL_RELATIVE];
	assign imm = q.ctrl[servo_pkg::CTRL_IMMEDIATE];
	assign up_act = actuated(nc, lvl[servo_pkg::IN_UPPER]); // see R9, see R10
	assign lo_act = actuated(nc, lvl[servo_pkg::IN_LOWER]); // see R9, see R10
	assign wr_fire = q.aw_got & q.w_got & ~q.bvalid;
	assign done = q.job == servo_pkg::JOB_RUN && job_done_in;
	assign busy_eff = q.job == servo_pkg::JOB_RUN && !job_done_in;
	assign ctrl_m = merge(servo_pkg::DATA_W'(q.ctrl), q.wdata, q.wstrb);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_q = q;
		next_q.start_p = 1'h0;
		next_q.abort_p = 1'h0;
		cmd_start = 1'h0;
		cmd_idx = '0;
		clr_err = 1'h0;
		launch = 1'h0;
		l_idx = '0;
		t_sel = '0;
		t_ok = 1'h0;
		motion = 1'h0;
		// bus write: address and data in either order
		if (s_axi_awvalid_in && !q.aw_got) begin
			next_q.aw_got = 1'h1;
			next_q.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !q.w_got) begin
			next_q.w_got = 1'h1;
			next_q.wdata = s_axi_wdata_in;
			next_q.wstrb = s_axi_wstrb_in;
		end
		if (wr_fire) begin
			next_q.aw_got = 1'h0;
			next_q.w_got = 1'h0;
			next_q.bvalid = 1'h1;
			next_q.bresp = reg_hit(q.awaddr) ? servo_pkg::RESP_OKAY : servo_pkg::RESP_SLVERR;
			if (q.awaddr == servo_pkg::OFS_CTRL) begin
				next_q.ctrl = ctrl_m[servo_pkg::CTRL_W-1:0];
			end else if (q.awaddr == servo_pkg::OFS_RANGE) begin
				next_q.range = merge(q.range, q.wdata, q.wstrb); // see R4
			end else if (q.awaddr == servo_pkg::OFS_CMD && q.wstrb[0]) begin
				cmd_start = q.wdata[servo_pkg::CMD_START];
				cmd_idx = q.wdata[servo_pkg::CMD_IDX_HI:servo_pkg::CMD_IDX_LO];
				clr_err = q.wdata[servo_pkg::CMD_CLR_ERR];
			end else if ((q.awaddr & servo_pkg::TARGET_MASK) == servo_pkg::OFS_TARGET) begin
				next_q.target[q.awaddr[servo_pkg::TGT_IDX_HI:servo_pkg::TGT_IDX_LO]] =
					merge(q.target[q.awaddr[servo_pkg::TGT_IDX_HI:servo_pkg::TGT_IDX_LO]], q.wdata, q.wstrb);
			end
		end
		if (q.bvalid && s_axi_bready_in) begin
			next_q.bvalid = 1'h0;
		end
		// bus read
		if (s_axi_arvalid_in && !q.rvalid) begin
			next_q.rvalid = 1'h1;
			next_q.rdata = read_word(q, s_axi_araddr_in, lvl);
			next_q.rresp = reg_hit(s_axi_araddr_in) ? servo_pkg::RESP_OKAY : servo_pkg::RESP_SLVERR;
		end
		if (q.rvalid && s_axi_rready_in) begin
			next_q.rvalid = 1'h0;
		end
		// enable handling
		if (rise[servo_pkg::IN_ENABLE]) begin
			next_q.en_armed = 1'h1;
		end
		next_q.drive_en = lvl[servo_pkg::IN_ENABLE] & (~io | q.en_armed | rise[servo_pkg::IN_ENABLE]); // see R17
		// input functions; mode specific ones only in i/o mode
		next_q.sp_zero = io & ~pos & ~mon & up_act & ~HALT_PRESET; // see R11, see R18
		next_q.hold = io & ~pos & ~mon & up_act & HALT_PRESET; // see R11, see R19
		next_q.invert = io & ~pos & ~mon & lo_act; // see R11, see R20
		next_q.fixed_sel = io & ~pos & lvl[servo_pkg::IN_SEL0]; // see R7, see R21
		next_q.blk_pos = ~pos & mon & up_act; // see R12
		next_q.blk_neg = ~pos & mon & lo_act; // see R13
		next_q.p_only = ~pos & mon & (up_act | lo_act); // see R12, see R13
		// positioning error, set wins over clear
		if (clr_err) begin
			next_q.pos_err = 1'h0;
		end
		if (pos && mon && (up_act || lo_act)) begin
			next_q.pos_err = 1'h1; // see R14, see R15
		end
		// job requests
		req = pos && (io ? rise[servo_pkg::IN_START] : cmd_start); // see R7, see R22
		req_idx = io ? lvl[servo_pkg::IN_SEL2:servo_pkg::IN_SEL0] : cmd_idx; // see R23
		if (done) begin
			next_q.job = servo_pkg::JOB_IDLE;
		end
		if (req && busy_eff && !imm) begin
			next_q.pending = 1'h1; // see R5, see R24
			next_q.pend_idx = req_idx;
		end else if (req) begin
			launch = 1'h1; // see R22, see R24
			l_idx = req_idx; // see R23
			next_q.pending = 1'h0;
		end else if (done && q.pending) begin
			launch = 1'h1; // see R5
			l_idx = q.pend_idx;
			next_q.pending = 1'h0;
		end
		if (launch) begin
			t_sel = q.target[l_idx];
			if (!tt) begin
				t_ok = 1'h1;
			end else if (rel) begin
				t_ok = $signed(t_sel) >= -$signed(q.range) && $signed(t_sel) <= $signed(q.range); // see R3
			end else begin
				t_ok = !t_sel[servo_pkg::SIGN_BIT] && $signed(t_sel) <= $signed(q.range); // see R1
			end
			motion = t_ok && !(tt && !rel && t_sel == q.setpos); // see R2
			if (!t_ok) begin
				next_q.pos_err = 1'h1;
			end
			if (motion) begin
				next_q.job = servo_pkg::JOB_RUN;
				next_q.start_p = 1'h1;
				next_q.abort_p = busy_eff;
				next_q.rel_p = rel;
				next_q.tgt = t_sel;
				next_q.idx = l_idx;
				next_q.setpos = rel ? q.setpos + t_sel : t_sel;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			q <= '0;
			q.job <= servo_pkg::JOB_IDLE;
			q.range <= servo_pkg::RANGE_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready_out = ~q.aw_got;
	assign s_axi_wready_out = ~q.w_got;
	assign s_axi_bvalid_out = q.bvalid;
	assign s_axi_bresp_out = q.bresp;
	assign s_axi_arready_out = ~q.rvalid;
	assign s_axi_rvalid_out = q.rvalid;
	assign s_axi_rdata_out = q.rdata;
	assign s_axi_rresp_out = q.rresp;
	assign spare_io_b_out = output_one_in;
	assign spare_io_b_oe_out = 1'h1; // see R8
	assign start_input_out = output_two_in;
	assign start_input_oe_out = ~(io & pos); // see R8
	assign drive_enable_out = q.drive_en;
	assign setpoint_zero_out = q.sp_zero;
	assign hold_out = q.hold;
	assign invert_out = q.invert;
	assign fixed_select_out = q.fixed_sel;
	assign block_pos_out = q.blk_pos;
	assign block_neg_out = q.blk_neg;
	assign p_only_out = q.p_only;
	assign pos_error_out = q.pos_err;
	assign job_start_out = q.start_p;
	assign job_abort_out = q.abort_p;
	assign job_relative_out = q.rel_p;
	assign job_target_out = q.tgt;
	assign job_index_out = q.idx;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	sequence s_deferred_req;
		req && busy_eff && !imm;
	endsequence

	sequence s_pend_done;
		done && q.pending && !req && !tt;
	endsequence

	a_abs_window: assert property (job_start_out && tt && !rel |-> // see R1
		!job_target_out[servo_pkg::SIGN_BIT] && $signed(job_target_out) <= $signed(q.range))
		else $error("absolute turntable target outside range");
	a_same_pos: assert property (launch && tt && !rel && q.target[l_idx] == q.setpos |=> !job_start_out) // see R2
		else $error("motion started toward present setpoint");
	a_rel_full: assert property (launch && tt && rel // see R3
		&& (q.target[l_idx] == q.range || q.target[l_idx] == -q.range) |=> job_start_out)
		else $error("full range relative move not started");
	a_last_wins: assert property (s_deferred_req ##1 !req && !done |-> q.pending && q.pend_idx == $past(req_idx)) // see R5
		else $error("pending slot not overwritten by latest request");
	a_pend_launch: assert property (s_pend_done |=> job_start_out && job_index_out == $past(q.pend_idx)) // see R5
		else $error("pending job not launched after completion");
	a_fieldbus_mask: assert property (!io |=> !setpoint_zero_out && !invert_out && !fixed_select_out) // see R7
		else $error("i/o only function active in fieldbus mode");
	a_shared_pin: assert property (io && pos |-> !start_input_oe_out && spare_io_b_oe_out) // see R8
		else $error("shared pin driven while used as input");
	a_nc_limit: assert property (nc && mon && !pos && !lvl[servo_pkg::IN_UPPER] ##1 mon && !pos // see R9
		|-> block_pos_out && p_only_out)
		else $error("low input not seen as actuated limit");
	a_limit_error: assert property (pos && mon && lo_act |=> pos_error_out) // see R15
		else $error("monitored limit gave no positioning error");
	a_enable_edge: assert property (io && !q.en_armed && !rise[servo_pkg::IN_ENABLE] |=> !drive_enable_out) // see R17
		else $error("drive enabled without a rising enable edge");
endmodule : servo_input_decoder
`default_nettype wire

/* File: verif/plc_switch_model.sv */
/*
 * far side model: limit switches with selectable contacts and a plc that drives enable, start and select pins.
 * assumes the bench changes its requests right after a rising edge of clk_sys_in.
 */
`timescale 1ns/1ns
`default_nettype none
module plc_switch_model (
	// clock
	input wire logic clk_sys_in,
	// requests: nc contacts, actuated switches {lower, upper}, plc {sel[2:0], start, enable}
	input wire logic nc_in,
	input wire logic [1:0] act_in,
	input wire logic [4:0] plc_in,
	// pins {sel2, sel1, sel0, start, lower, upper, enable}
	output logic [6:0] pin_out
);
	// ****************************************
	// pin drive
	// ****************************************
	initial pin_out = 7'h00;
	// an nc contact opens when actuated, so the pin goes low
	always @(posedge clk_sys_in) begin
		pin_out <= {plc_in[4:1], act_in ^ {2{nc_in}}, plc_in[0]};
	end
endmodule : plc_switch_model
`default_nettype wire

/* File: verif/test_servo_input_function_decoder.sv */
/*
 * self-checking bench of the input decoder: axi4-lite tasks, pin scenarios, positioning jobs.
 * assumes plc_switch_model drives the pins and the bench plays the positioning logic.
 */
`timescale 1ns/1ns
`default_nettype none
module test_servo_input_function_decoder;
	// ****************************************
	// signals and instances
	// ****************************************
	logic clk_sys_in = 1'h0, nrst_in = 1'h0, nc = 1'h0, done = 1'h0, s, sa;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, awr, wr_, bv, arr, rv;
	logic [7:0] aa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd, d, st;
	logic [1:0] bresp, rresp, r, act = 2'h0;
	logic [4:0] plc = 5'h00;
	logic [6:0] pin;
	logic [2:0] si;
	logic de, sz, ho, inv, fs, bp, bn, po, pe, js, ja, jr, soe, so1, so2, sbe;
	logic [31:0] jt;
	logic [2:0] jx;
	int n_fail = 0, compares = 0, cyc = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	plc_switch_model far (.clk_sys_in(clk_sys_in), .nc_in(nc), .act_in(act), .plc_in(plc), .pin_out(pin));
	servo_input_decoder dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(aa), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr_), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(br), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rresp), .enable_input_in(pin[0]), .upper_limit_input_in(pin[1]),
		.lower_limit_input_in(pin[2]), .start_input_in(pin[3]), .select_bit0_input_in(pin[4]),
		.select_bit1_input_in(pin[5]), .select_bit2_input_in(pin[6]), .start_input_out(so2),
		.start_input_oe_out(soe), .spare_io_b_in(1'h0), .spare_io_b_out(so1), .spare_io_b_oe_out(sbe),
		.output_one_in(1'h1), .output_two_in(1'h0), .drive_enable_out(de), .setpoint_zero_out(sz),
		.hold_out(ho), .invert_out(inv), .fixed_select_out(fs), .block_pos_out(bp), .block_neg_out(bn),
		.p_only_out(po), .pos_error_out(pe), .job_done_in(done), .job_start_out(js), .job_abort_out(ja),
		.job_relative_out(jr), .job_target_out(jt), .job_index_out(jx));
	// ****************************************
	// tasks
	// ****************************************
	task automatic complete_run;
		if (n_fail == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
		compares++;
		if (v !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask : chk
	task automatic w(input logic [7:0] a, input logic [31:0] v);
		awv <= 1'h1; wv <= 1'h1; aa <= a; wd <= v; br <= 1'h1;
		fork
			begin do @(posedge clk_sys_in); while (!awr); awv <= 1'h0; end
			begin do @(posedge clk_sys_in); while (!wr_); wv <= 1'h0; end
		join
		do @(posedge clk_sys_in); while (!bv);
		r = bresp;
		br <= 1'h0;
		@(posedge clk_sys_in);
	endtask : w
	task automatic rdr(input logic [7:0] a);
		arv <= 1'h1; ara <= a; rr <= 1'h1;
		do @(posedge clk_sys_in); while (!arr);
		arv <= 1'h0;
		do @(posedge clk_sys_in); while (!rv);
		d = rd; r = rresp; rr <= 1'h0;
		@(posedge clk_sys_in);
	endtask : rdr
	task automatic watch(input int n);
		s = 1'h0;
		repeat (n) begin
			@(posedge clk_sys_in);
			if (js === 1'h1) begin s = 1'h1; si = jx; st = jt; sa = ja; end
		end
	endtask : watch
	task automatic go(input logic [2:0] ix);
		plc <= {ix, 2'h3};
		watch(8);
		plc <= {ix, 2'h1};
		repeat (3) @(posedge clk_sys_in);
	endtask : go
	task automatic finish_job;
		done <= 1'h1;
		@(posedge clk_sys_in);
		done <= 1'h0;
		watch(4);
	endtask : finish_job
	task automatic pins(input logic [1:0] a);
		act <= a;
		repeat (6) @(posedge clk_sys_in);
	endtask : pins
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 5000) begin n_fail++; complete_run; end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (10) @(posedge clk_sys_in);
		nrst_in <= 1'h1;
		rdr(8'h04); chk("range", d, 32'h2710);
		rdr(8'h14); chk("unmapped", {r, d[29:0]}, 32'h8000_0000);
		w(8'h14, 32'h0); chk("wr unmapped", r, 32'h2);
		pins(2'h0); chk("enable idle", de, 0);
		plc <= 5'h01; pins(2'h0); chk("enable", de, 1);
		pins(2'h1); chk("zero", {ho, sz}, 1);
		pins(2'h2); chk("invert", {sz, inv}, 1);
		nc <= 1'h1; w(8'h00, 32'h18); pins(2'h0); chk("nc idle", {bp, bn, po}, 0);
		pins(2'h1); chk("upper", {bp, bn, po}, 32'h5);
		pins(2'h2); chk("lower", {bp, bn, po}, 32'h3);
		nc <= 1'h0; w(8'h00, 32'h0c); pins(2'h1); chk("mon err", pe, 1);
		chk("start pin in", {soe, sbe, so1, so2}, 32'h6);
		pins(2'h0); w(8'h0c, 32'h10); w(8'h00, 32'h04); pins(2'h2); chk("no err", pe, 0);
		pins(2'h0);
		w(8'h24, 32'd100); w(8'h38, 32'd600); w(8'h3c, 32'd700); w(8'h34, 32'h2711);
		go(3'h1); chk("job1", {s, si, st[15:0]}, {1'b1, 3'h1, 16'd100});
		go(3'h5); chk("deferred", s, 0);
		go(3'h6); chk("deferred2", s, 0);
		finish_job; chk("last wins", {s, si, st[15:0]}, {1'b1, 3'h6, 16'd600});
		w(8'h00, 32'h24); go(3'h7); chk("abort", {s, sa, si}, {1'b1, 1'b1, 3'h7});
		finish_job; w(8'h00, 32'h44);
		go(3'h5); chk("tt range", {s, pe}, 1);
		w(8'h0c, 32'h10); go(3'h7); chk("tt same", {s, pe}, 0);
		go(3'h6); chk("tt move", s, 1);
		finish_job; w(8'h00, 32'hc4); w(8'h30, 32'hffff_d8f0);
		go(3'h4); chk("rel full", {s, jr}, 32'h3);
		finish_job; plc <= 5'h05; w(8'h00, 32'h02); pins(2'h0); chk("fixed", {fs, ho, sz}, 32'h4);
		w(8'h00, 32'h01); pins(2'h3); chk("fieldbus", {sz, inv, fs}, 0);
		w(8'h00, 32'h05); w(8'h0c, 32'h07); rdr(8'h10); chk("status", d[14:0], 15'h3327);
		complete_run;
	end
endmodule : test_servo_input_function_decoder
`default_nettype wire
